// ==== design/lbw_map.svh ====
`ifndef LBW_MAP_SVH
`define LBW_MAP_SVH
// Message stream geometry
`define LBW_TAG_W 9
`define LBW_DATA_W 64
`define LBW_WORD_W 52
`define LBW_CMD_W 3
// Message tags recognised by the stage
`define LBW_TAG_FRAG 9'h0a0
`define LBW_TAG_CANCEL 9'h0a1
`define LBW_TAG_SETUP 9'h0a2
`define LBW_TAG_SYNC 9'h0a3
`define LBW_TAG_WCTRL 9'h0a4
`define LBW_TAG_LAYOUT 9'h0a5
// Commands posted to the interface write FIFO
`define LBW_CMD_WRITE 3'h0
`define LBW_CMD_DISCARD 3'h1
`define LBW_CMD_RESUME 3'h4
// Incoming fragment field positions
`define LBW_IN_STENCIL_LSB 32
`define LBW_IN_COUNT_LSB 40
`define LBW_IN_WID_LSB 48
// Write control message: bit 0 enables writes
`define LBW_WCTRL_EN_BIT 0
// Buffer layout message fields
`define LBW_LAY_W 17
`define LBW_LAY_DEPTH_LSB 0
`define LBW_LAY_STW_LSB 2
`define LBW_LAY_STPOS_LSB 4
`define LBW_LAY_FCW_LSB 7
`define LBW_LAY_FCPOS_LSB 9
`define LBW_LAY_WIDW_BIT 12
`define LBW_LAY_WIDPOS_LSB 13
// Field start = base + step * position code
`define LBW_START_BASE 16
`define LBW_START_STEP 4
// Reset values: writes off, 16-bit depth, other fields absent
`define LBW_WEN_RESET 1'h0
`define LBW_LAY_RESET 17'h00000
`endif

// ==== design/lbw_pkg.sv ====
package lbw_pkg;
  typedef enum {LBW_ST_RUN, LBW_ST_SETUP_FWD} lbw_state_t;
  typedef logic [2:0] lbw_cmd_t;
endpackage : lbw_pkg

// ==== design/lbw_fifo.sv ====
`timescale 1ns/10ps
module lbw_fifo #(
  parameter int W = 73,
  parameter int D = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic in_ready_r, in_ready_nxt, out_valid_r, out_valid_nxt;
  logic [W-1:0] out_data_r, out_data_nxt;
  logic push, pop_mem;

  ////////////////////////////////////////////////////////////////////////
  // Head word sits in a register so the consumer sees flop outputs
  always_comb begin
    push = in_valid && in_ready_r;
    pop_mem = (cnt_r != '0) && (!out_valid_r || out_ready);
    wr_ptr_nxt = push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
    rd_ptr_nxt = pop_mem ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
    cnt_nxt = (AW+1)'(cnt_r + (AW+1)'(push) - (AW+1)'(pop_mem));
    // Registered ready: room left after this cycle's traffic
    in_ready_nxt = cnt_nxt < (AW+1)'(D);
    out_valid_nxt = out_valid_r;
    out_data_nxt = out_data_r;
    if (pop_mem) begin
      out_valid_nxt = 1'b1;
      out_data_nxt = mem_r[rd_ptr_r];
    end else if (out_ready) begin
      out_valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b0;
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
      in_ready_r <= in_ready_nxt;
      out_valid_r <= out_valid_nxt;
      out_data_r <= out_data_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;
endmodule : lbw_fifo

// ==== design/lbw_write_stage.sv ====
// Behaviour
// - Enabled fragment write repacks data and posts a write request.
// - Fragment write with writes disabled posts a discard request.
// - Cancel-write message posts a discard request.
// - Setup message posts resume-read first, then forwards when room exists.
// - Sync message held until writes drained, then forwarded.
// - No request posted while the interface write FIFO is full.
// - Write control and layout messages update settings, not forwarded.
// - Other messages forwarded unchanged when room exists, then removed.
// - Stage creates no new messages; only forwarded ones leave downstream.
// - Requests carry no address; interface pairs them in order.
// - Input: depth low 32, stencil at 32, count at 40, window at 48.
// - Packed word configurable 16 to 52 bits, 4-bit steps.
// - Layout supports documented field widths and 4-bit-aligned starts.
// - Narrower stored fields keep their least significant bits.
// - Depth saturates to largest value fitting configured depth width.
// - Overlapping bits: depth over stencil over count over window.
// - Bits no field covers are zero.
`timescale 1ns/10ps
`include "lbw_map.svh"
module lbw_write_stage (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [`LBW_TAG_W-1:0] in_tag,
  input wire logic [`LBW_DATA_W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [`LBW_TAG_W-1:0] out_tag,
  output logic [`LBW_DATA_W-1:0] out_data,
  input wire logic out_ready,
  output logic wr_en,
  output lbw_pkg::lbw_cmd_t wr_cmd,
  output logic [`LBW_WORD_W-1:0] wr_data,
  input wire logic wr_full,
  input wire logic writes_drained
);
  localparam int MW = `LBW_TAG_W + `LBW_DATA_W;

  ////////////////////////////////////////////////////////////////////////
  // Layout decoding and packing
  // Width code 0/1/2 gives 0/4/8 bits; code 3 reads as 8
  function automatic logic [3:0] field_width(input logic [1:0] code);
    logic [3:0] w;
    w = 4'h0;
    if (code == 2'h1) begin
      w = 4'h4;
    end else if (code != 2'h0) begin
      w = 4'h8;
    end
    return w;
  endfunction : field_width

  function automatic logic [5:0] field_start(input logic [3:0] pos);
    return 6'(`LBW_START_BASE + `LBW_START_STEP * int'(pos));
  endfunction : field_start

  // Bits past the top of the word are simply dropped
  function automatic logic [`LBW_WORD_W-1:0] place_field(
    input logic [`LBW_WORD_W-1:0] w,
    input logic [7:0] v,
    input logic [5:0] start,
    input logic [3:0] width
  );
    logic [`LBW_WORD_W-1:0] r;
    r = w;
    for (int i = 0; i < `LBW_WORD_W; i++) begin
      if (i >= int'(start) && i < int'(start) + int'(width)) begin
        r[i] = v[3'(i - int'(start))];
      end
    end
    return r;
  endfunction : place_field

  function automatic logic [5:0] depth_width(input logic [1:0] code);
    logic [5:0] n;
    n = 6'h20;
    if (code == 2'h0) begin
      n = 6'h10;
    end else if (code == 2'h1) begin
      n = 6'h18;
    end
    return n;
  endfunction : depth_width

  function automatic logic [`LBW_WORD_W-1:0] pack_word(
    input logic [`LBW_DATA_W-1:0] d,
    input logic [`LBW_LAY_W-1:0] lay
  );
    logic [`LBW_WORD_W-1:0] r;
    logic [31:0] depth;
    logic [31:0] dmax;
    logic [5:0] n;
    r = '0;
    n = depth_width(lay[`LBW_LAY_DEPTH_LSB +: 2]);
    dmax = 32'hffffffff >> (6'h20 - n);
    depth = d[31:0];
    if (depth > dmax) begin
      depth = dmax;
    end
    // Lowest priority first so higher fields overwrite overlaps
    r = place_field(r, {4'h0, d[`LBW_IN_WID_LSB +: 4]},
      field_start(lay[`LBW_LAY_WIDPOS_LSB +: 4]),
      lay[`LBW_LAY_WIDW_BIT] ? 4'h4 : 4'h0);
    r = place_field(r, d[`LBW_IN_COUNT_LSB +: 8],
      field_start({1'b0, lay[`LBW_LAY_FCPOS_LSB +: 3]}),
      field_width(lay[`LBW_LAY_FCW_LSB +: 2]));
    r = place_field(r, d[`LBW_IN_STENCIL_LSB +: 8],
      field_start({1'b0, lay[`LBW_LAY_STPOS_LSB +: 3]}),
      field_width(lay[`LBW_LAY_STW_LSB +: 2]));
    for (int i = 0; i < 32; i++) begin
      if (i < int'(n)) begin
        r[i] = depth[i];
      end
    end
    return r;
  endfunction : pack_word

  ////////////////////////////////////////////////////////////////////////
  // Input buffer
  logic q_valid, q_ready;
  logic [MW-1:0] q_word;
  logic [`LBW_TAG_W-1:0] q_tag;
  logic [`LBW_DATA_W-1:0] q_data;

  lbw_fifo #(.W(MW), .D(16)) u_in_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(in_valid),
    .in_data({in_tag, in_data}),
    .in_ready(in_ready),
    .out_valid(q_valid),
    .out_data(q_word),
    .out_ready(q_ready)
  );
  assign q_tag = q_word[MW-1 -: `LBW_TAG_W];
  assign q_data = q_word[`LBW_DATA_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Message handling
  lbw_pkg::lbw_state_t state_r, state_nxt;
  logic wen_r, wen_nxt;
  logic [`LBW_LAY_W-1:0] lay_r, lay_nxt;
  logic wr_en_r, wr_en_nxt;
  lbw_pkg::lbw_cmd_t wr_cmd_r, wr_cmd_nxt;
  logic [`LBW_WORD_W-1:0] wr_data_r, wr_data_nxt, packed_word;
  logic out_valid_r, out_valid_nxt;
  logic [`LBW_TAG_W-1:0] out_tag_r, out_tag_nxt;
  logic [`LBW_DATA_W-1:0] out_data_r, out_data_nxt;
  logic post_ok, room, fwd;

  assign packed_word = pack_word(q_data, lay_r);

  always_comb begin
    // A request posted last cycle may not show in wr_full yet
    post_ok = !wr_full && !wr_en_r;
    room = !out_valid_r || out_ready;
    state_nxt = state_r;
    wen_nxt = wen_r;
    lay_nxt = lay_r;
    wr_en_nxt = 1'b0;
    wr_cmd_nxt = wr_cmd_r;
    wr_data_nxt = wr_data_r;
    q_ready = 1'b0;
    fwd = 1'b0;
    unique case (state_r)
      lbw_pkg::LBW_ST_RUN: begin
        if (q_valid) begin
          unique case (q_tag)
            `LBW_TAG_WCTRL: begin
              wen_nxt = q_data[`LBW_WCTRL_EN_BIT];
              q_ready = 1'b1;
            end
            `LBW_TAG_LAYOUT: begin
              lay_nxt = q_data[`LBW_LAY_W-1:0];
              q_ready = 1'b1;
            end
            `LBW_TAG_FRAG, `LBW_TAG_CANCEL: begin
              if (post_ok) begin
                // No address travels; the interface pairs in order
                wr_en_nxt = 1'b1;
                q_ready = 1'b1;
                if (q_tag == `LBW_TAG_FRAG && wen_r) begin
                  wr_cmd_nxt = `LBW_CMD_WRITE;
                  wr_data_nxt = packed_word;
                end else begin
                  wr_cmd_nxt = `LBW_CMD_DISCARD;
                end
              end
            end
            `LBW_TAG_SETUP: begin
              if (post_ok) begin
                wr_en_nxt = 1'b1;
                wr_cmd_nxt = `LBW_CMD_RESUME;
                state_nxt = lbw_pkg::LBW_ST_SETUP_FWD;
              end
            end
            `LBW_TAG_SYNC: begin
              // Wait out the request still in flight as well
              if (writes_drained && !wr_en_r && room) begin
                fwd = 1'b1;
              end
            end
            default: begin
              fwd = room;
            end
          endcase
        end
      end
      lbw_pkg::LBW_ST_SETUP_FWD: begin
        if (room) begin
          fwd = 1'b1;
          state_nxt = lbw_pkg::LBW_ST_RUN;
        end
      end
    endcase
    if (fwd) begin
      q_ready = 1'b1;
    end
    out_valid_nxt = out_valid_r && !out_ready;
    out_tag_nxt = out_tag_r;
    out_data_nxt = out_data_r;
    if (fwd) begin
      out_valid_nxt = 1'b1;
      out_tag_nxt = q_tag;
      out_data_nxt = q_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= lbw_pkg::LBW_ST_RUN;
      wen_r <= `LBW_WEN_RESET;
      lay_r <= `LBW_LAY_RESET;
      wr_en_r <= 1'b0;
      wr_cmd_r <= `LBW_CMD_WRITE;
      wr_data_r <= '0;
      out_valid_r <= 1'b0;
      out_tag_r <= '0;
      out_data_r <= '0;
    end else begin
      state_r <= state_nxt;
      wen_r <= wen_nxt;
      lay_r <= lay_nxt;
      wr_en_r <= wr_en_nxt;
      wr_cmd_r <= wr_cmd_nxt;
      wr_data_r <= wr_data_nxt;
      out_valid_r <= out_valid_nxt;
      out_tag_r <= out_tag_nxt;
      out_data_r <= out_data_nxt;
    end
  end

  assign out_valid = out_valid_r;
  assign out_tag = out_tag_r;
  assign out_data = out_data_r;
  assign wr_en = wr_en_r;
  assign wr_cmd = wr_cmd_r;
  assign wr_data = wr_data_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic run_head;
  assign run_head = q_valid && state_r == lbw_pkg::LBW_ST_RUN;

  a_write_post: assert property (
    run_head && q_tag == `LBW_TAG_FRAG && wen_r && post_ok |=> wr_en
    && wr_cmd == `LBW_CMD_WRITE && wr_data == $past(packed_word))
    else $error("enabled fragment did not post packed write");
  a_discard_off: assert property (
    run_head && q_tag == `LBW_TAG_FRAG && !wen_r && post_ok
    |=> wr_en && wr_cmd == `LBW_CMD_DISCARD)
    else $error("disabled fragment did not post discard");
  a_cancel_post: assert property (
    run_head && q_tag == `LBW_TAG_CANCEL && post_ok
    |=> wr_en && wr_cmd == `LBW_CMD_DISCARD)
    else $error("cancel did not post discard");
  // Forward follows the resume request as soon as downstream has room
  a_setup_order: assert property (
    run_head && q_tag == `LBW_TAG_SETUP && post_ok
    |=> (wr_en && wr_cmd == `LBW_CMD_RESUME && !$rose(out_valid))
    and ((!out_valid || out_ready) |=> out_valid
    && out_tag == `LBW_TAG_SETUP))
    else $error("setup not resumed then forwarded");
  a_sync_gate: assert property (
    out_valid && out_tag == `LBW_TAG_SYNC
    && (!$past(out_valid) || $past(out_ready))
    |-> $past(writes_drained) && !$past(wr_en))
    else $error("sync forwarded before writes drained");
  a_no_post_full: assert property (
    wr_en |-> !$past(wr_full) && !$past(wr_en))
    else $error("request posted while interface full");
  a_cfg_consume: assert property (
    run_head && (q_tag == `LBW_TAG_LAYOUT || q_tag == `LBW_TAG_WCTRL)
    |-> q_ready ##1 !($rose(out_valid) && $changed(out_tag)) && !wr_en)
    else $error("setting message leaked downstream");
  a_layout_take: assert property (
    run_head && q_tag == `LBW_TAG_LAYOUT
    |=> lay_r == $past(q_data[`LBW_LAY_W-1:0]))
    else $error("layout setting not updated");
  a_out_hold: assert property (
    out_valid && !out_ready
    |=> out_valid && $stable(out_tag) && $stable(out_data))
    else $error("forwarded message dropped while stalled");
  a_depth_sat: assert property (
    lay_r == `LBW_LAY_RESET && q_data[31:16] != 16'h0000
    |-> packed_word[15:0] == 16'hffff
    && packed_word[`LBW_WORD_W-1:16] == '0)
    else $error("depth not saturated or upper bits not zero");

  c_write: cover property (wr_en && wr_cmd == `LBW_CMD_WRITE);
  c_resume: cover property (wr_en && wr_cmd == `LBW_CMD_RESUME ##[1:4]
    out_valid && out_tag == `LBW_TAG_SETUP);
  c_sync_wait: cover property (run_head && q_tag == `LBW_TAG_SYNC
    && !writes_drained ##[1:20] out_valid && out_tag == `LBW_TAG_SYNC);
  c_full_stall: cover property (!in_ready ##1 in_ready);
endmodule : lbw_write_stage

// ==== bench/lbw_iface_model.sv ====
`timescale 1ns/10ps
`include "lbw_map.svh"
module lbw_iface_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire lbw_pkg::lbw_cmd_t wr_cmd,
  input wire logic [`LBW_WORD_W-1:0] wr_data,
  input wire logic hold_full,
  input wire logic hold_busy,
  output logic wr_full,
  output logic writes_drained
);
  lbw_pkg::lbw_cmd_t cmd_q[$];
  logic [`LBW_WORD_W-1:0] data_q[$];
  logic [4:0] cnt_r;
  logic [1:0] div_r;
  logic reads_ok_r;
  time last_t;
  ////////////////////////////////////////////////////////////////////////
  // Retires one queued write every fourth cycle, so full is really seen
  always @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_r <= 5'h00;
      div_r <= 2'h0;
      wr_full <= 1'b0;
      reads_ok_r <= 1'b1;
    end else begin
      div_r <= div_r + 2'h1;
      if (wr_en) begin
        cmd_q.push_back(wr_cmd);
        data_q.push_back(wr_data);
        last_t = $time;
      end
      cnt_r <= cnt_r + 5'(wr_en) - 5'((div_r == 2'h3) && (cnt_r != 5'h00));
      if (wr_en && wr_cmd == `LBW_CMD_RESUME) begin
        reads_ok_r <= 1'b0;
      end else if (cnt_r == 5'h00) begin
        reads_ok_r <= 1'b1;
      end
      wr_full <= hold_full || (cnt_r >= 5'h06);
    end
  end
  assign writes_drained = !hold_busy && (cnt_r == 5'h00) && !wr_en;
endmodule : lbw_iface_model

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`include "lbw_map.svh"
module tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic in_valid = 1'b0;
  logic [8:0] in_tag = 9'h000;
  logic [63:0] in_data = 64'h0;
  logic out_ready = 1'b1;
  logic hold_full = 1'b0;
  logic hold_busy = 1'b0;
  logic in_ready, out_valid, wr_en, wr_full, writes_drained;
  logic [8:0] out_tag;
  logic [63:0] out_data;
  lbw_pkg::lbw_cmd_t wr_cmd;
  logic [51:0] wr_data;
  logic [8:0] oq_tag[$];
  logic [63:0] oq_data[$];
  time last_fwd;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;

  always #50 core_clk = ~core_clk;

  lbw_write_stage uut (.core_clk(core_clk), .reset_n(reset_n),
    .in_valid(in_valid), .in_tag(in_tag), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_tag(out_tag),
    .out_data(out_data), .out_ready(out_ready), .wr_en(wr_en),
    .wr_cmd(wr_cmd), .wr_data(wr_data), .wr_full(wr_full),
    .writes_drained(writes_drained));
  lbw_iface_model m (.core_clk(core_clk), .reset_n(reset_n), .wr_en(wr_en),
    .wr_cmd(wr_cmd), .wr_data(wr_data), .hold_full(hold_full),
    .hold_busy(hold_busy), .wr_full(wr_full),
    .writes_drained(writes_drained));
  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (reset_n && out_valid && out_ready) begin
      oq_tag.push_back(out_tag);
      oq_data.push_back(out_data);
      last_fwd = $time;
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      err_total++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk

  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  function automatic logic [63:0] frag(input logic [31:0] z,
    input logic [7:0] s, input logic [7:0] c, input logic [7:0] g);
    return {g, c, s, z};
  endfunction : frag

  // Request held until the edge that samples in_ready high
  task send(input logic [8:0] t, input logic [63:0] d);
    @(posedge core_clk);
    in_valid <= 1'b1;
    in_tag <= t;
    in_data <= d;
    @(posedge core_clk);
    while (!in_ready) @(posedge core_clk);
    in_valid <= 1'b0;
  endtask : send

  task wait_n(input int n, input bit on_req);
    for (int i = 0; i < 200; i++) begin
      if (on_req ? m.cmd_q.size() > n : oq_tag.size() > n) break;
      @(posedge core_clk);
    end
  endtask : wait_n

  task req_is(input int n, input logic [2:0] c, input bit use_d,
    input logic [51:0] e);
    wait_n(n, 1'b1);
    chk(m.cmd_q.size() == n + 1 && m.cmd_q[n] === c &&
      (!use_d || m.data_q[n] === e), "request");
  endtask : req_is
  ////////////////////////////////////////////////////////////////////////
  task t_modes;
    int n;
    n = m.cmd_q.size();
    send(`LBW_TAG_FRAG, frag(32'h0001_2345, 8'hff, 8'hff, 8'hff));
    req_is(n, `LBW_CMD_DISCARD, 1'b0, 52'h0);
    send(`LBW_TAG_WCTRL, 64'h1);
    send(`LBW_TAG_FRAG, frag(32'h0001_2345, 8'hff, 8'hff, 8'hff));
    req_is(n + 1, `LBW_CMD_WRITE, 1'b1, 52'h000000000ffff);
    chk(oq_tag.size() == 0, "settings forwarded");
    $display("done modes");
  endtask : t_modes

  task t_layout(input logic [16:0] lay, input logic [63:0] d,
    input logic [51:0] e);
    int n;
    send(`LBW_TAG_LAYOUT, {47'h0, lay});
    n = m.cmd_q.size();
    send(`LBW_TAG_FRAG, d);
    req_is(n, `LBW_CMD_WRITE, 1'b1, e);
    chk(oq_tag.size() == 0, "layout forwarded");
    $display("done layout");
  endtask : t_layout

  task t_seq;
    int n, k;
    n = m.cmd_q.size();
    k = oq_tag.size();
    send(`LBW_TAG_CANCEL, 64'h0);
    req_is(n, `LBW_CMD_DISCARD, 1'b0, 52'h0);
    send(`LBW_TAG_SETUP, 64'habc);
    req_is(n + 1, `LBW_CMD_RESUME, 1'b0, 52'h0);
    wait_n(k, 1'b0);
    chk(oq_tag.size() == k + 1 && oq_tag[k] === `LBW_TAG_SETUP &&
      oq_data[k] === 64'habc && m.last_t < last_fwd, "setup");
    send(9'h011, 64'hdead_beef_0123_4567);
    wait_n(k + 1, 1'b0);
    chk(oq_tag.size() == k + 2 && oq_tag[k + 1] === 9'h011 &&
      oq_data[k + 1] === 64'hdead_beef_0123_4567, "pass on");
    chk(m.cmd_q.size() == n + 2, "extra request");
    $display("done sequence");
  endtask : t_seq

  task t_full;
    int n;
    @(posedge core_clk);
    hold_full <= 1'b1;
    n = m.cmd_q.size();
    send(`LBW_TAG_FRAG, frag(32'h0, 8'h0, 8'h0, 8'h0));
    repeat (20) @(posedge core_clk);
    chk(m.cmd_q.size() == n, "posted while full");
    hold_full <= 1'b0;
    req_is(n, `LBW_CMD_WRITE, 1'b1, 52'h0);
    $display("done full");
  endtask : t_full

  task t_sync;
    int k;
    @(posedge core_clk);
    hold_busy <= 1'b1;
    k = oq_tag.size();
    send(`LBW_TAG_SYNC, 64'h5);
    repeat (30) @(posedge core_clk);
    chk(oq_tag.size() == k, "sync early");
    hold_busy <= 1'b0;
    wait_n(k, 1'b0);
    chk(oq_tag.size() == k + 1 && oq_tag[k] === `LBW_TAG_SYNC, "sync");
    $display("done sync");
  endtask : t_sync

  // Downstream stalls for 40 cycles so the input refuses, then drains in order
  task t_fifo;
    int k, got, bad;
    k = oq_tag.size();
    got = 0;
    bad = 0;
    @(posedge core_clk);
    out_ready <= 1'b0;
    in_valid <= 1'b1;
    in_tag <= 9'h011;
    in_data <= 64'h0;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (in_ready) got++;
      in_data <= 64'(got);
    end
    in_valid <= 1'b0;
    chk(got >= 16 && got < 40 && oq_tag.size() == k, "no refusal");
    out_ready <= 1'b1;
    wait_n(k + got - 1, 1'b0);
    for (int i = 0; i < got && k + i < oq_data.size(); i++) begin
      if (oq_data[k + i] !== 64'(i)) bad++;
    end
    chk(oq_tag.size() == k + got && bad == 0, "drain order");
    $display("done fifo");
  endtask : t_fifo
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk(in_ready === 1'b0 && out_valid === 1'b0 && wr_en === 1'b0, "reset");
    @(posedge core_clk);
    chk(in_ready === 1'b1 && out_tag === 9'h000 && wr_data === 52'h0,
      "ready after reset");
    t_modes();
    t_layout(17'h0b8a9, frag(32'h0100_0000, 8'h5a, 8'h3c, 8'h09),
      52'h0009c5affffff);
    t_layout(17'h0988a, frag(32'h1234_5678, 8'hee, 8'ha7, 8'h03),
      52'h0000712345678);
    t_layout(17'h00714, frag(32'h0000_abcd, 8'h5a, 8'hc3, 8'hff),
      52'h0000c30a0abcd);
    t_seq();
    t_full();
    t_sync();
    t_fifo();
    conclude();
  end
endmodule : tb_top
